//--- fm_cal_sequencer.sv
// Calibration sequencer and register slave for the modulated synthesizer
`timescale 1ns/1ns
module fm_cal_sequencer #(
  parameter logic [15:0] SETTLE_CYCLES = 16'h0100,
  parameter logic [15:0] REF_COUNT = 16'h0040,
  parameter int FBW = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Synthesizer side
  input wire logic ref_clk_in,
  input wire logic osc_clk_in,
  input wire logic lock_in,
  input wire logic lock_lost_in,
  input wire logic self_clocked_fallback,
  output logic mod_enable,
  output logic [1:0] mod_depth,
  output logic mod_up,
  output logic [7:0] cal_dac,
  output logic lock_search,
  output logic chip_reset_req,
  output logic lock_loss_irq
);
  import fm_cal_pkg::*;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [FBW-1:0] center_reg;
  logic [7:0] dac_reg;
  logic done_reg, pass_reg;
  cal_state_t state_reg;
  logic dph_wr_reg;
  logic [7:0] dph_addr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] status_w;
  logic aph;
  assign aph = hsel && hready && htrans[1];
  assign status_w = {16'h0000, dac_reg, 3'h0, self_clocked_fallback,
                     state_reg != ST_IDLE, pass_reg, done_reg, lock_in};

  // Address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      dph_wr_reg <= aph && hwrite;
      if (aph) begin
        dph_addr_reg <= haddr[7:0];
      end
      if (aph && !hwrite) begin
        unique case (haddr[7:0])
          OFF_CTRL: rdata_reg <= ctrl_reg;
          OFF_STATUS: rdata_reg <= status_w;
          OFF_CENTER: rdata_reg <= {{(32-FBW){1'b0}}, center_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ---------------------------------------------------------------
  // Control register and write side effects
  // ---------------------------------------------------------------
  logic wr_ctrl, chg_in_div, chg_fb_mult, chg_rate, cal_start, cal_done_w;
  logic [1:0] old_depth, new_depth;
  logic lock_search_reg, chip_reset_reg, irq_reg;
  assign wr_ctrl = dph_wr_reg && (dph_addr_reg == OFF_CTRL);
  assign old_depth = ctrl_reg[F_DEPTH +: 2];
  assign new_depth = hwdata[F_DEPTH +: 2];
  assign chg_in_div = wr_ctrl && (hwdata[F_IN_DIV +: 3] != ctrl_reg[F_IN_DIV +: 3]);
  assign chg_fb_mult = wr_ctrl && (hwdata[F_FB_MULT +: 5] != ctrl_reg[F_FB_MULT +: 5]);
  assign chg_rate = wr_ctrl && (hwdata[F_RATE] != ctrl_reg[F_RATE]);
  assign cal_start = wr_ctrl && (old_depth == 2'b00) && (new_depth != 2'b00);

  // Control register, reset leaves depth at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata & CTRL_MASK;
    end
  end

  // Lock search, chip reset and lock loss request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_search_reg <= 1'b0;
      chip_reset_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      lock_search_reg <= chg_in_div || chg_fb_mult || cal_done_w;
      chip_reset_reg <= chg_fb_mult && ctrl_reg[F_LL_RESET];
      irq_reg <= lock_lost_in && ctrl_reg[F_LL_IRQ];
    end
  end
  assign lock_search = lock_search_reg;
  assign chip_reset_req = chip_reset_reg;
  assign lock_loss_irq = irq_reg;

  // ---------------------------------------------------------------
  // Edge detection of reference and oscillator inputs
  // ---------------------------------------------------------------
  logic ref_d_reg, osc_d_reg, ref_rise, osc_rise;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_d_reg <= 1'b0;
      osc_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= ref_clk_in;
      osc_d_reg <= osc_clk_in;
    end
  end
  assign ref_rise = ref_clk_in && !ref_d_reg;
  assign osc_rise = osc_clk_in && !osc_d_reg;

  // ---------------------------------------------------------------
  // Triangle modulation rate generator
  // ---------------------------------------------------------------
  logic [10:0] mod_cnt_reg, mod_period;
  logic [6:0] q_sel;
  logic mod_up_reg;
  assign q_sel = ctrl_reg[F_RATE] ? Q_FAST : Q_SLOW;
  assign mod_period = {4'h0, q_sel} * ({8'h00, ctrl_reg[F_IN_DIV +: 3]} + 11'h001);

  // Period counter on reference edges; direction flips each half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_cnt_reg <= 11'h000;
      mod_up_reg <= 1'b1;
    end else if (chg_in_div || chg_rate) begin
      mod_cnt_reg <= 11'h000;
      mod_up_reg <= 1'b1;
    end else if (ref_rise) begin
      if (mod_cnt_reg >= mod_period - 11'h001) begin
        mod_cnt_reg <= 11'h000;
      end else begin
        mod_cnt_reg <= mod_cnt_reg + 11'h001;
      end
      mod_up_reg <= (mod_cnt_reg + 11'h001) < (mod_period >> 1);
    end
  end
  assign mod_up = mod_up_reg;

  // ---------------------------------------------------------------
  // Calibration state machine
  // ---------------------------------------------------------------
  logic [15:0] settle_reg, ref_cnt_reg;
  logic [FBW-1:0] fb_cnt_reg;
  logic [2:0] bit_reg;
  logic fb_ovf, ref_full, dac_err;
  logic signed [FBW+1:0] delta_w, err_w;
  assign ref_full = ref_rise && (ref_cnt_reg == REF_COUNT - 16'h0001);
  assign fb_ovf = osc_rise && (&fb_cnt_reg);
  assign delta_w = $signed({2'b00, fb_cnt_reg}) - $signed({2'b00, center_reg});
  assign err_w = $signed({{(FBW+2-W_DELTA){1'b0}}, ctrl_reg[F_DELTA +: W_DELTA]}) - delta_w;
  assign dac_err = (bit_reg == 3'h0) &&
                   ((err_w[FBW+1] && dac_reg == 8'h01) ||
                    (!err_w[FBW+1] && err_w != '0 && dac_reg == 8'hff));
  assign cal_done_w = (state_reg == ST_DECIDE) && (bit_reg == 3'h0);

  // Sequencing of settle, center count and delta passes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      settle_reg <= 16'h0000;
    end else if (wr_ctrl && new_depth == 2'b00) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (cal_start) state_reg <= ST_SETTLE_C;
        ST_SETTLE_C, ST_SETTLE_D: begin
          if (settle_reg == SETTLE_CYCLES - 16'h0001) begin
            state_reg <= (state_reg == ST_SETTLE_C) ? ST_COUNT_C : ST_COUNT_D;
          end
        end
        ST_COUNT_C: if (fb_ovf) state_reg <= ST_IDLE;
          else if (ref_full) state_reg <= ST_SETTLE_D;
        ST_COUNT_D: if (fb_ovf) state_reg <= ST_IDLE;
          else if (ref_full) state_reg <= ST_DECIDE;
        ST_DECIDE: state_reg <= (bit_reg == 3'h0) ? ST_IDLE : ST_SETTLE_D;
      endcase
      if (state_reg == ST_SETTLE_C || state_reg == ST_SETTLE_D) begin
        settle_reg <= settle_reg + 16'h0001;
      end else begin
        settle_reg <= 16'h0000;
      end
    end
  end

  // Reference and feedback counters, held in the decide phase, cleared in idle and settle phases
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_reg <= 16'h0000;
      fb_cnt_reg <= '0;
    end else if (state_reg == ST_COUNT_C || state_reg == ST_COUNT_D) begin
      if (ref_rise) ref_cnt_reg <= ref_cnt_reg + 16'h0001;
      if (osc_rise && !ref_full) fb_cnt_reg <= fb_cnt_reg + {{(FBW-1){1'b0}}, 1'b1};
    end else if (state_reg != ST_DECIDE) begin
      ref_cnt_reg <= 16'h0000;
      fb_cnt_reg <= '0;
    end
  end

  // Center count stored once per calibration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      center_reg <= '0;
    end else if (state_reg == ST_COUNT_C && ref_full && !fb_ovf) begin
      center_reg <= fb_cnt_reg;
    end
  end

  // Successive approximation of the calibration D/A
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_reg <= 8'h00;
      bit_reg <= DAC_TOP_BIT;
    end else if (cal_start) begin
      dac_reg <= DAC_START;
      bit_reg <= DAC_TOP_BIT;
    end else if (state_reg == ST_DECIDE) begin
      if (err_w[FBW+1]) dac_reg[bit_reg] <= 1'b0;
      if (bit_reg != 3'h0) begin
        dac_reg[bit_reg - 3'h1] <= 1'b1;
        bit_reg <= bit_reg - 3'h1;
      end
    end
  end
  assign cal_dac = dac_reg;

  // Finished and succeeded flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_reg <= 1'b0;
      pass_reg <= 1'b0;
    end else if (cal_start) begin
      done_reg <= 1'b0;
      pass_reg <= 1'b1;
    end else begin
      if (cal_done_w) done_reg <= 1'b1;
      if (fb_ovf && (state_reg == ST_COUNT_C || state_reg == ST_COUNT_D)) pass_reg <= 1'b0;
      else if (cal_done_w && dac_err) pass_reg <= 1'b0;
      else if ((chg_in_div || chg_fb_mult || chg_rate) && old_depth != 2'b00) begin
        pass_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Modulation enable towards the loop
  // ---------------------------------------------------------------
  logic mod_en_reg;
  logic [1:0] mod_depth_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_en_reg <= 1'b0;
      mod_depth_reg <= 2'b00;
    end else begin
      mod_en_reg <= !self_clocked_fallback && old_depth != 2'b00 &&
                    (state_reg == ST_IDLE || state_reg == ST_SETTLE_D ||
                     state_reg == ST_COUNT_D || state_reg == ST_DECIDE);
      mod_depth_reg <= self_clocked_fallback ? 2'b00 : old_depth;
    end
  end
  assign mod_enable = mod_en_reg;
  assign mod_depth = mod_depth_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_fallback_mod_off: assert property (self_clocked_fallback |=> !mod_enable)
    else $error("modulation on in self-clocked fallback");
  a_depth_zero_off: assert property (ctrl_reg[F_DEPTH +: 2] == 2'b00 |=> !mod_enable)
    else $error("modulation on with zero depth");
  a_start_flags: assert property (cal_start |=> pass_reg && !done_reg && state_reg == ST_SETTLE_C)
    else $error("start flags wrong");
  a_last_done: assert property (cal_done_w |=> done_reg && state_reg == ST_IDLE ##1 !lock_search)
    else $error("finished flag not set");
  a_mult_reset: assert property (chg_fb_mult && ctrl_reg[F_LL_RESET] |=>
    chip_reset_req ##1 !chip_reset_req)
    else $error("chip reset not requested");
  a_search_start: assert property (chg_in_div || chg_fb_mult |=> lock_search)
    else $error("lock search missing");
  a_irq_req: assert property (lock_lost_in && ctrl_reg[F_LL_IRQ] |=> lock_loss_irq)
    else $error("lock loss request missing");
  a_center_hold: assert property (state_reg == ST_COUNT_D |=> $stable(center_reg))
    else $error("center count changed in delta pass");
  a_settle_len: assert property ($rose(state_reg == ST_COUNT_C) |->
    $past(state_reg) == ST_SETTLE_C && $past(settle_reg) == SETTLE_CYCLES - 16'h0001)
    else $error("settle interval wrong");
  a_invalid_cal: assert property (chg_rate && old_depth != 2'b00 && !cal_start |=> !pass_reg)
    else $error("calibration not invalidated");
  a_mod_period: assert property (mod_cnt_reg < mod_period || $changed(mod_period))
    else $error("modulation counter beyond period");
  c_cal_start: cover property (cal_start);
  c_cal_pass: cover property (cal_done_w && !dac_err);
  c_cal_ovf: cover property (fb_ovf && state_reg == ST_COUNT_D);
  c_irq: cover property (lock_loss_irq);
endmodule

//--- fm_cal_pkg.sv
// Constants for the modulated synthesizer calibration sequencer
package fm_cal_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CENTER = 8'h08;
  // ---------------------------------------------------------------
  // Control field layout
  // ---------------------------------------------------------------
  localparam int F_IN_DIV = 0;
  localparam int F_FB_MULT = 3;
  localparam int F_OUT_DIV = 8;
  localparam int F_LL_RESET = 11;
  localparam int F_LL_IRQ = 12;
  localparam int F_RATE = 13;
  localparam int F_DEPTH = 14;
  localparam int F_DELTA = 16;
  localparam int W_DELTA = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h03ff_ffff;
  // Status bit layout
  localparam int S_LOCK = 0;
  localparam int S_DONE = 1;
  localparam int S_PASS = 2;
  localparam int S_BUSY = 3;
  localparam int S_FALLBACK = 4;
  localparam int S_DAC = 8;
  // ---------------------------------------------------------------
  // Modulation and calibration constants
  // ---------------------------------------------------------------
  localparam logic [6:0] Q_FAST = 7'h28;
  localparam logic [6:0] Q_SLOW = 7'h50;
  localparam logic [7:0] DAC_START = 8'h80;
  localparam logic [2:0] DAC_TOP_BIT = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE_C, ST_COUNT_C, ST_SETTLE_D, ST_COUNT_D, ST_DECIDE
  } cal_state_t;
endpackage

//--- tb_pll_fm_calibration_sequencer.sv
// Self-checking bench for the modulated synthesizer calibration sequencer
`timescale 1ns/1ns
module tb_pll_fm_calibration_sequencer;
  import fm_cal_pkg::*;
  // Expected delta for multiplier 6 (scale 480) at one percent depth, rounded
  localparam logic [9:0] DELTA_1PCT = 10'(((6 + 4) * 480 * 1 + 50) / 100);
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, mod_depth;
  logic [2:0] hsize;
  logic ref_clk_in, osc_clk_in, lock_in, lock_lost_in, self_clocked_fallback;
  logic mod_enable, mod_up, lock_search, chip_reset_req, lock_loss_irq;
  logic [7:0] cal_dac;
  logic [3:0] tick;
  logic [1:0] osc_div;
  logic ref_prev;
  int n_errors, checks_done, n_search, n_rst, ref_rises, mod_cnt, r0;
  assign hready = hreadyout;
  fm_cal_sequencer #(.SETTLE_CYCLES(16'h0004), .REF_COUNT(16'h0008), .FBW(16)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ref_clk_in(ref_clk_in),
    .osc_clk_in(osc_clk_in), .lock_in(lock_in), .lock_lost_in(lock_lost_in),
    .self_clocked_fallback(self_clocked_fallback), .mod_enable(mod_enable),
    .mod_depth(mod_depth), .mod_up(mod_up), .cal_dac(cal_dac), .lock_search(lock_search),
    .chip_reset_req(chip_reset_req), .lock_loss_irq(lock_loss_irq));
  // ---------------------------------------------------------------
  // Clock, reference period 4 cycles, oscillator faster while modulating
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    tick <= tick + 4'h1;
    ref_clk_in <= tick[1];
    ref_prev <= ref_clk_in;
    if (ref_clk_in === 1'b1 && ref_prev === 1'b0) ref_rises <= ref_rises + 1;
    osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
    if (mod_enable === 1'b1 || osc_div == 2'h2) osc_clk_in <= ~osc_clk_in;
    if (lock_search === 1'b1) n_search <= n_search + 1;
    if (chip_reset_req === 1'b1) n_rst <= n_rst + 1;
    if (mod_enable === 1'b1) mod_cnt <= mod_cnt + 1;
  end
  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    checks_done++;
    if (seen !== expd) begin
      n_errors++;
      $display("ERROR at %0t ns: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // Waits for the slave's ready, cutting a hang short
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        check(32'h0, 32'h1);
        stop_test();
      end
      @(posedge hclk);
    end
  endtask
  // One AHB-Lite single word transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Polls the finished flag through the status register
  task automatic wait_done();
    int n;
    n = 0;
    bus(1'b0, OFF_STATUS, 32'h0);
    while (rd[S_DONE] !== 1'b1) begin
      n++;
      if (n > 1000) begin
        check(32'h0, 32'h1);
        stop_test();
      end
      bus(1'b0, OFF_STATUS, 32'h0);
    end
  endtask
  // Waits for the rising half of the triangle to begin
  task automatic wait_up();
    int n;
    n = 0;
    @(posedge hclk);
    while (mod_up !== 1'b0) begin
      n++;
      if (n > 2000) begin
        check(32'h0, 32'h1);
        stop_test();
      end
      @(posedge hclk);
    end
    while (mod_up !== 1'b1) begin
      n++;
      if (n > 2000) begin
        check(32'h0, 32'h1);
        stop_test();
      end
      @(posedge hclk);
    end
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    lock_in = 1'b0;
    lock_lost_in = 1'b0;
    self_clocked_fallback = 1'b0;
    tick = 4'h0;
    osc_div = 2'h0;
    osc_clk_in = 1'b0;
    ref_clk_in = 1'b0;
    ref_prev = 1'b0;
    n_errors = 0;
    checks_done = 0;
    n_search = 0;
    n_rst = 0;
    ref_rises = 0;
    mod_cnt = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({31'h0, mod_enable}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    bus(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    // Multiplier change with lock-loss reset enabled
    bus(1'b1, OFF_CTRL, 32'h0000_0800);
    bus(1'b1, OFF_CTRL, 32'h0000_0830);
    idle(4);
    check(n_rst, 1);
    check(n_search, 1);
    // Output divider change, lock-loss reset cleared: no lock search, no reset
    bus(1'b1, OFF_CTRL, 32'h0000_0230);
    idle(4);
    check(n_rst, 1);
    check(n_search, 1);
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rd, 32'h0000_0230);
    // Calibration with expected delta 0: every bit cleared, range error
    bus(1'b1, OFF_CTRL, 32'h0000_6230);
    idle(2);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd[2:1], 2'h2);
    wait_done();
    check(rd[S_PASS], 1'b0);
    check(rd[15:8], 8'h00);
    check(cal_dac, 8'h00);
    idle(4);
    check(n_search, 2);
    check(mod_cnt > 0, 1'b1);
    check({31'h0, mod_enable}, 32'h1);
    check({30'h0, mod_depth}, 32'h1);
    // Unmodulated oscillator rises every 6 cycles over 28 to 31 cycles
    bus(1'b0, OFF_CENTER, 32'h0);
    check(rd > 32'h3 && rd < 32'h7, 1'b1);
    // Triangle period in reference edges, Q of 40, divider 0
    wait_up();
    r0 = ref_rises;
    wait_up();
    check(ref_rises - r0, {25'h0, Q_FAST});
    // Depth 00 turns modulation off
    bus(1'b1, OFF_CTRL, {6'h0, DELTA_1PCT, 16'h2230});
    idle(4);
    check({30'h0, mod_depth, mod_enable}, 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0);
    check(rd, {6'h0, DELTA_1PCT, 16'h2230});
    // Full-scale expected delta, rate change mid-run spoils the result
    bus(1'b1, OFF_CTRL, 32'h03ff_a230);
    idle(3);
    bus(1'b1, OFF_CTRL, 32'h03ff_8230);
    idle(2);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd[S_PASS], 1'b0);
    check(rd[S_DONE], 1'b0);
    wait_done();
    check(rd[15:8], 8'hff);
    check(rd[S_PASS], 1'b0);
    // Fallback mode keeps modulation off
    bus(1'b1, OFF_CTRL, 32'h0000_0230);
    self_clocked_fallback <= 1'b1;
    bus(1'b1, OFF_CTRL, 32'h0000_4230);
    idle(4);
    check({30'h0, mod_depth, mod_enable}, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd[S_FALLBACK], 1'b1);
    self_clocked_fallback <= 1'b0;
    // Lock loss interrupt gated by its enable, lock flag shown
    bus(1'b1, OFF_CTRL, 32'h0000_0230);
    lock_lost_in <= 1'b1;
    lock_in <= 1'b1;
    idle(3);
    check(lock_loss_irq, 1'b0);
    bus(1'b1, OFF_CTRL, 32'h0000_1230);
    idle(3);
    check(lock_loss_irq, 1'b1);
    lock_lost_in <= 1'b0;
    idle(3);
    check(lock_loss_irq, 1'b0);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd[S_LOCK], 1'b1);
    stop_test();
  end
endmodule
